//--- rtl/mpsc_pkg.sv
package mpsc_pkg;
    // Selection function codes for the digital input terminals
    localparam logic [7:0] FN_SEL1       = 8'h02;
    localparam logic [7:0] FN_SEL2       = 8'h03;
    localparam logic [7:0] FN_SEL3       = 8'h04;
    localparam logic [7:0] FN_SEL4       = 8'h05;
    localparam logic [7:0] FN_ZERO_SERVO = 8'h2E;
    localparam logic [7:0] FN_SPD_POS    = 8'h33;
    localparam logic [7:0] FN_POS_EN     = 8'h34;
    localparam int         NUM_TERM      = 8;
    localparam int         NUM_SECT      = 16;
    // Signed limit of section counts; unsigned upper limit of offsets
    localparam logic signed [15:0] CNT_MAX   = 16'sh270F;
    localparam logic signed [15:0] CNT_MIN   = -16'sh270F;
    localparam logic [15:0]        OFS_MAX   = 16'h270F;
    // No-Z indication value of the bias monitor
    localparam logic signed [31:0] ZBIAS_NONE = 32'sh0000270F;
    // Positioning max frequency, 0.1 Hz units: 0.1 to 100 Hz
    localparam logic [15:0] PFMAX_MIN    = 16'h0001;
    localparam logic [15:0] PFMAX_MAX    = 16'h03E8;
    localparam logic [15:0] PFMAX_RST    = 16'h03E8;
    localparam logic [15:0] PPR_RST      = 16'h0400;
    // Position mode selector values
    localparam logic        PMODE_FMIN   = 1'b0;
    localparam logic        PMODE_ZLOCK  = 1'b1;
    // Register indices (word addresses)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_TERMFN_LO = 8'h01;
    localparam logic [7:0] REG_TERMFN_HI = 8'h02;
    localparam logic [7:0] REG_PFMAX     = 8'h03;
    localparam logic [7:0] REG_OFFSET    = 8'h04;
    localparam logic [7:0] REG_PPR       = 8'h05;
    localparam logic [7:0] REG_STATUS    = 8'h06;
    localparam logic [7:0] REG_ZBIAS     = 8'h07;
    localparam logic [7:0] REG_TARGET    = 8'h08;
    localparam logic [7:0] REG_SECT_BASE = 8'h20;
    // Control register fields
    localparam int CTRL_VECTOR_BIT = 0;
    localparam int CTRL_PMODE_BIT  = 1;
    typedef enum logic [1:0] {MPSC_IDLE, MPSC_WAIT_Z, MPSC_HOLD} mpsc_state_t;
endpackage : mpsc_pkg

//--- rtl/mpsc_top.sv
`timescale 1ns/1ps
module mpsc_top (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               arst_n,
    // Register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    // Command terminals and drive state
    input  wire logic [7:0]         term_in,
    input  wire logic               run_cmd,
    input  wire logic               below_fmin,
    // Encoder
    input  wire logic signed [31:0] enc_position,
    input  wire logic               enc_z,
    // Toward speed regulator
    output logic                    position_mode,
    output logic signed [31:0]      position_reference,
    output logic signed [31:0]      selected_section_target,
    output logic [15:0]             freq_limit,
    output logic                    ramp_set_one,
    output logic [3:0]              section_index,
    output logic signed [31:0]      z_bias
);
    logic                       closed_loop_vector_mode;
    logic                       pos_mode_sel;
    logic [7:0]                 term_fn [mpsc_pkg::NUM_TERM];
    logic [15:0]                pfmax;
    logic [15:0]                origin_offset;
    logic [15:0]                ppr;
    logic signed [15:0]         sect_rot [mpsc_pkg::NUM_SECT];
    logic signed [15:0]         sect_pls [mpsc_pkg::NUM_SECT];
    logic signed [31:0]         z_capture;
    logic                       z_seen;
    logic                       z_prev;
    logic signed [31:0]         origin;
    mpsc_pkg::mpsc_state_t      state;
    logic [3:0]                 sel_bits;
    logic                       zero_servo_in;
    logic                       spd_pos_in;
    logic                       position_command_enable_input;
    logic signed [31:0]         next_target;
    logic                       z_edge;
    logic signed [15:0]         wr_cnt;

    function automatic logic signed [15:0] clamp_cnt(input logic signed [15:0] v);
        if (v > mpsc_pkg::CNT_MAX) begin
            return mpsc_pkg::CNT_MAX;
        end else if (v < mpsc_pkg::CNT_MIN) begin
            return mpsc_pkg::CNT_MIN;
        end
        return v;
    endfunction : clamp_cnt

    always_comb begin
        sel_bits      = 4'h0;
        zero_servo_in = 1'b0;
        spd_pos_in    = 1'b0;
        position_command_enable_input = 1'b0;
        for (int i = 0; i < mpsc_pkg::NUM_TERM; i++) begin
            unique case (term_fn[i])
                mpsc_pkg::FN_SEL1:       sel_bits[0] = sel_bits[0] | term_in[i];
                mpsc_pkg::FN_SEL2:       sel_bits[1] = sel_bits[1] | term_in[i];
                mpsc_pkg::FN_SEL3:       sel_bits[2] = sel_bits[2] | term_in[i];
                mpsc_pkg::FN_SEL4:       sel_bits[3] = sel_bits[3] | term_in[i];
                mpsc_pkg::FN_ZERO_SERVO: zero_servo_in = zero_servo_in | term_in[i];
                mpsc_pkg::FN_SPD_POS:    spd_pos_in = spd_pos_in | term_in[i];
                mpsc_pkg::FN_POS_EN:
                    position_command_enable_input = position_command_enable_input | term_in[i];
                default: ;
            endcase
        end
    end

    assign z_edge = enc_z & ~z_prev;
    assign wr_cnt = clamp_cnt(reg_wdata[15:0]);

    // Register writes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            closed_loop_vector_mode <= 1'b0;
            pos_mode_sel            <= mpsc_pkg::PMODE_FMIN;
            pfmax                   <= mpsc_pkg::PFMAX_RST;
            origin_offset           <= 16'h0000;
            ppr                     <= mpsc_pkg::PPR_RST;
            for (int i = 0; i < mpsc_pkg::NUM_TERM; i++) begin
                term_fn[i] <= 8'h00;
            end
            for (int i = 0; i < mpsc_pkg::NUM_SECT; i++) begin
                sect_rot[i] <= 16'sh0000;
                sect_pls[i] <= 16'sh0000;
            end
        end else if (reg_wr) begin
            if (reg_addr == mpsc_pkg::REG_CTRL) begin
                closed_loop_vector_mode <= reg_wdata[mpsc_pkg::CTRL_VECTOR_BIT];
                pos_mode_sel            <= reg_wdata[mpsc_pkg::CTRL_PMODE_BIT];
            end
            if (reg_addr == mpsc_pkg::REG_TERMFN_LO) begin
                for (int i = 0; i < 4; i++) begin
                    term_fn[i] <= reg_wdata[8*i +: 8];
                end
            end
            if (reg_addr == mpsc_pkg::REG_TERMFN_HI) begin
                for (int i = 0; i < 4; i++) begin
                    term_fn[i+4] <= reg_wdata[8*i +: 8];
                end
            end
            if (reg_addr == mpsc_pkg::REG_PFMAX) begin
                if (reg_wdata[15:0] < mpsc_pkg::PFMAX_MIN) begin
                    pfmax <= mpsc_pkg::PFMAX_MIN;
                end else if (reg_wdata[15:0] > mpsc_pkg::PFMAX_MAX) begin
                    pfmax <= mpsc_pkg::PFMAX_MAX;
                end else begin
                    pfmax <= reg_wdata[15:0];
                end
            end
            if (reg_addr == mpsc_pkg::REG_OFFSET) begin
                origin_offset <= (reg_wdata[15:0] > mpsc_pkg::OFS_MAX) ?
                                 mpsc_pkg::OFS_MAX : reg_wdata[15:0];
            end
            if (reg_addr == mpsc_pkg::REG_PPR) begin
                ppr <= reg_wdata[15:0];
            end
            if (reg_addr[7:5] == mpsc_pkg::REG_SECT_BASE[7:5]) begin
                if (reg_addr[0]) begin
                    sect_pls[reg_addr[4:1]] <= wr_cnt;
                end else begin
                    sect_rot[reg_addr[4:1]] <= wr_cnt;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            z_prev    <= 1'b0;
            z_capture <= 32'sh00000000;
            z_seen    <= 1'b0;
        end else begin
            z_prev <= enc_z;
            if (z_edge) begin
                z_capture <= enc_position;
                z_seen    <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            z_bias <= mpsc_pkg::ZBIAS_NONE;
        end else if (z_seen) begin
            z_bias <= enc_position - z_capture;
        end else begin
            z_bias <= mpsc_pkg::ZBIAS_NONE;
        end
    end

    // Entry to position mode; leaving zero-servo or run drops it at once
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state  <= mpsc_pkg::MPSC_IDLE;
            origin <= 32'sh00000000;
        end else begin
            unique case (state)
                mpsc_pkg::MPSC_IDLE: begin
                    if (run_cmd && zero_servo_in && below_fmin) begin
                        if (pos_mode_sel == mpsc_pkg::PMODE_FMIN) begin
                            origin <= enc_position;
                            state  <= mpsc_pkg::MPSC_HOLD;
                        end else begin
                            state <= mpsc_pkg::MPSC_WAIT_Z;
                        end
                    end
                end
                mpsc_pkg::MPSC_WAIT_Z: begin
                    if (!(run_cmd && zero_servo_in)) begin
                        state <= mpsc_pkg::MPSC_IDLE;
                    end else if (z_edge) begin
                        origin <= enc_position + 32'(origin_offset);
                        state  <= mpsc_pkg::MPSC_HOLD;
                    end
                end
                mpsc_pkg::MPSC_HOLD: begin
                    if (!(run_cmd && zero_servo_in)) begin
                        state <= mpsc_pkg::MPSC_IDLE;
                    end
                end
            endcase
        end
    end

    // signed arithmetic keeps direction
    // Widen before the product so large rotation counts do not wrap
    assign next_target = 32'(sect_rot[section_index]) * 32'($signed({1'b0, ppr}))
                       + 32'(sect_pls[section_index]);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            section_index <= 4'h0;
        end else if (state != mpsc_pkg::MPSC_HOLD) begin
            section_index <= 4'h0;
        end else if (closed_loop_vector_mode && spd_pos_in && position_command_enable_input) begin
            section_index <= sel_bits;
        end
    end

    // Outputs toward the regulator
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            position_mode           <= 1'b0;
            position_reference      <= 32'sh00000000;
            selected_section_target <= 32'sh00000000;
            freq_limit              <= mpsc_pkg::PFMAX_RST;
            ramp_set_one            <= 1'b0;
        end else begin
            position_mode           <= (state == mpsc_pkg::MPSC_HOLD);
            selected_section_target <= next_target;
            position_reference      <= (section_index == 4'h0) ? origin : origin + next_target;
            freq_limit              <= pfmax;
            ramp_set_one            <= (state == mpsc_pkg::MPSC_HOLD);
        end
    end

    // Register reads, one cycle later; unmapped reads zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= 32'h00000000;
            unique case (reg_addr)
                mpsc_pkg::REG_CTRL:
                    reg_rdata <= {30'h00000000, pos_mode_sel, closed_loop_vector_mode};
                mpsc_pkg::REG_TERMFN_LO:
                    reg_rdata <= {term_fn[3], term_fn[2], term_fn[1], term_fn[0]};
                mpsc_pkg::REG_TERMFN_HI:
                    reg_rdata <= {term_fn[7], term_fn[6], term_fn[5], term_fn[4]};
                mpsc_pkg::REG_PFMAX:  reg_rdata <= {16'h0000, pfmax};
                mpsc_pkg::REG_OFFSET: reg_rdata <= {16'h0000, origin_offset};
                mpsc_pkg::REG_PPR:    reg_rdata <= {16'h0000, ppr};
                mpsc_pkg::REG_STATUS:
                    reg_rdata <= {24'h000000, section_index, 1'b0, z_seen, state};
                mpsc_pkg::REG_ZBIAS:  reg_rdata <= z_bias;
                mpsc_pkg::REG_TARGET: reg_rdata <= position_reference;
                default: begin
                    if (reg_addr[7:5] == mpsc_pkg::REG_SECT_BASE[7:5]) begin
                        reg_rdata <= reg_addr[0] ? 32'(sect_pls[reg_addr[4:1]])
                                                 : 32'(sect_rot[reg_addr[4:1]]);
                    end
                end
            endcase
        end
    end
endmodule : mpsc_top

//--- bench/mpsc_props.sv
`timescale 1ns/1ps
module mpsc_props (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               arst_n,
    // Register port
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_rdata,
    // Commands and encoder
    input wire logic               run_cmd,
    input wire logic               below_fmin,
    input wire logic signed [31:0] enc_position,
    input wire logic               enc_z,
    // Regulator side
    input wire logic               position_mode,
    input wire logic signed [31:0] position_reference,
    input wire logic [15:0]        freq_limit,
    input wire logic               ramp_set_one,
    input wire logic [3:0]         section_index,
    input wire logic signed [31:0] z_bias
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Cycles since the last index mark, held at 7, zero before the first one
    logic [2:0] z_age;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            z_age <= 3'h0;
        end else if ($rose(enc_z)) begin
            z_age <= 3'h1;
        end else if (z_age != 3'h0 && z_age != 3'h7) begin
            z_age <= z_age + 3'h1;
        end
    end
    sequence s_quiet;
        position_mode && $stable(section_index) && !reg_wr && !enc_z;
    endsequence
    sequence s_settled;
        s_quiet [*3];
    endsequence
    a_ramp_follows: assert property (ramp_set_one == position_mode)
        else $error("ramp flag differs from mode");
    a_freq_range: assert property (freq_limit >= mpsc_pkg::PFMAX_MIN &&
        freq_limit <= mpsc_pkg::PFMAX_MAX) else $error("freq limit out of range");
    a_zbias_none: assert property (z_age == 3'h0 |-> z_bias == mpsc_pkg::ZBIAS_NONE)
        else $error("bias not 9999 before mark");
    a_zbias_tracks: assert property (z_age == 3'h7 |-> z_bias - $past(z_bias) ==
        $past(enc_position) - $past(enc_position, 2)) else $error("bias not tracking");
    a_mode_entry: assert property ($rose(position_mode) |->
        $past(run_cmd, 2) && $past(below_fmin, 2)) else $error("mode without cause");
    a_mode_exit: assert property (!run_cmd |-> ##2 !position_mode)
        else $error("mode kept after run drop");
    a_rdata_stands: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved");
    a_ref_steady: assert property (s_settled |=> $stable(position_reference))
        else $error("reference moved");
endmodule : mpsc_props
bind mpsc_top mpsc_props i_mpsc_props (.sys_clk, .arst_n, .reg_wr, .reg_rd, .reg_rdata,
    .run_cmd, .below_fmin, .enc_position, .enc_z, .position_mode, .position_reference,
    .freq_limit, .ramp_set_one, .section_index, .z_bias);

//--- bench/mpsc_enc_model.sv
`timescale 1ns/1ps
module mpsc_enc_model #(
    parameter int PPR = 1024
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               arst_n,
    // Goal from the bench
    input  wire logic signed [31:0] goal,
    // Encoder
    output logic signed [31:0]      enc_position,
    output logic                    enc_z
);
    // One count a cycle, so no mark is ever skipped
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            enc_position <= 32'sh00000005;
        end else if (enc_position < goal) begin
            enc_position <= enc_position + 32'sh1;
        end else if (enc_position > goal) begin
            enc_position <= enc_position - 32'sh1;
        end
    end
    // Mark is a level while the shaft sits on it
    assign enc_z = (enc_position % PPR) == 0;
endmodule : mpsc_enc_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic               sys_clk = 1'b0;
    logic               arst_n = 1'b0;
    logic [7:0]         reg_addr = 8'h00;
    logic [31:0]        reg_wdata = 32'h0;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [7:0]         term_in = 8'h00;
    logic               run_cmd = 1'b0;
    logic               below_fmin = 1'b0;
    logic signed [31:0] goal = 32'sh00000005;
    logic [31:0]        reg_rdata;
    logic signed [31:0] enc_position;
    logic               enc_z;
    logic               position_mode;
    logic signed [31:0] position_reference;
    logic signed [31:0] selected_section_target;
    logic [15:0]        freq_limit;
    logic               ramp_set_one;
    logic [3:0]         section_index;
    logic signed [31:0] z_bias;
    int                 n_mismatch = 0;
    int                 checks = 0;
    int                 cyc = 0;
    always #4 sys_clk = ~sys_clk;
    mpsc_top i_mpsc_top (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .term_in, .run_cmd, .below_fmin, .enc_position, .enc_z,
        .position_mode, .position_reference, .selected_section_target, .freq_limit,
        .ramp_set_one, .section_index, .z_bias);
    mpsc_enc_model i_mpsc_enc_model (.sys_clk, .arst_n, .goal, .enc_position, .enc_z);
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata, e);
    endtask : rd
    // Terminals: code on 0..3, zero-servo 5, select 6, enable 7
    task automatic sel(input logic [3:0] c, input logic en, input logic [3:0] ix,
                       input logic [31:0] tg, input logic [31:0] rf);
        @(posedge sys_clk);
        term_in <= {en, 3'h6, c};
        repeat (4) @(posedge sys_clk);
        #1 chk("section_index", {28'h0, section_index}, {28'h0, ix});
        chk("section_target", selected_section_target, tg);
        chk("position_reference", position_reference, rf);
    endtask : sel
    task automatic mode_is(input logic m);
        repeat (4) @(posedge sys_clk);
        #1 chk("position_mode", {31'h0, position_mode}, {31'h0, m});
    endtask : mode_is
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        #1 chk("z_bias", z_bias, mpsc_pkg::ZBIAS_NONE);
        chk("freq_limit", {16'h0, freq_limit}, {16'h0, mpsc_pkg::PFMAX_RST});
        rd(mpsc_pkg::REG_ZBIAS, mpsc_pkg::ZBIAS_NONE, "zbias_reg");
        rd(8'h1F, 32'h0, "unmapped");
        wr(mpsc_pkg::REG_PFMAX, 32'h0);
        rd(mpsc_pkg::REG_PFMAX, 32'h1, "pfmax_low");
        chk("freq_limit_low", {16'h0, freq_limit}, 32'h1);
        wr(mpsc_pkg::REG_PFMAX, 32'h7D0);
        rd(mpsc_pkg::REG_PFMAX, 32'h3E8, "pfmax_high");
        wr(mpsc_pkg::REG_CTRL, 32'h1);
        wr(mpsc_pkg::REG_TERMFN_LO, {mpsc_pkg::FN_SEL4, mpsc_pkg::FN_SEL3,
            mpsc_pkg::FN_SEL2, mpsc_pkg::FN_SEL1});
        wr(mpsc_pkg::REG_TERMFN_HI, {mpsc_pkg::FN_POS_EN, mpsc_pkg::FN_SPD_POS,
            mpsc_pkg::FN_ZERO_SERVO, 8'h00});
        wr(8'h26, 32'h1);
        wr(8'h27, 32'h200);
        wr(8'h2B, 32'hFFFFFD00);
        wr(8'h3E, 32'hFFFFFFFE);
        wr(8'h3F, 32'h2EE0);
        rd(8'h3F, 32'h270F, "pulse15_clamp");
        // host ordering
        // Run, then zero-servo, then enable and code
        @(posedge sys_clk);
        run_cmd <= 1'b1;
        below_fmin <= 1'b1;
        @(posedge sys_clk);
        term_in <= 8'h20;
        mode_is(1'b1);
        chk("origin", position_reference, 32'h5);
        chk("ramp_set_one", {31'h0, ramp_set_one}, 32'h1);
        sel(4'h3, 1'b1, 4'h3, 32'h600, 32'h605);
        sel(4'h5, 1'b1, 4'h5, 32'hFFFFFD00, 32'hFFFFFD05);
        sel(4'hF, 1'b1, 4'hF, 32'h1F0F, 32'h1F14);
        sel(4'h3, 1'b0, 4'hF, 32'h1F0F, 32'h1F14);
        sel(4'h0, 1'b1, 4'h0, 32'h0, 32'h5);
        wr(mpsc_pkg::REG_CTRL, 32'h0);
        sel(4'h3, 1'b1, 4'h0, 32'h0, 32'h5);
        @(posedge sys_clk);
        run_cmd <= 1'b0;
        term_in <= 8'h20;
        mode_is(1'b0);
        wr(mpsc_pkg::REG_CTRL, 32'h3);
        wr(mpsc_pkg::REG_OFFSET, 32'h64);
        @(posedge sys_clk);
        run_cmd <= 1'b1;
        mode_is(1'b0);
        @(posedge sys_clk);
        goal <= 32'sh00000400;
        repeat (1030) @(posedge sys_clk);
        #1 chk("zlock_mode", {31'h0, position_mode}, 32'h1);
        chk("zlock_origin", position_reference, 32'h464);
        chk("z_bias_at_mark", z_bias, 32'h0);
        @(posedge sys_clk);
        goal <= 32'sh00000406;
        repeat (10) @(posedge sys_clk);
        #1 chk("z_bias_moved", z_bias, 32'h6);
        rd(mpsc_pkg::REG_ZBIAS, 32'h6, "zbias_reg_moved");
        conclude();
    end
endmodule : tb_top
